// *** rtl/smsc_core.sv ***
// command interpreter, mode control and drive state of the switch monitor
// assumes spi pins from the host, switch comparator levels from the analog front end
`timescale 1ns/1ps
`default_nettype none
`include "smsc_map.svh"

module smsc_core #(
    parameter int NUM_INPUTS = `SMSC_NUM_INPUTS,
    parameter int NUM_PROG   = `SMSC_NUM_PROG
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   mosi,
    output logic                        miso,
    input  wire logic [NUM_INPUTS-1:0]  sw_below_thresh,
    input  wire logic                   wake_n_in,
    output logic                        wake_n_out,
    output logic                        wake_n_oe,
    output smsc_pkg::smsc_drive_t       drive,
    output smsc_pkg::smsc_analog_t      analog_mux_out,
    output smsc_pkg::smsc_timers_t      sleep_timers,
    output smsc_pkg::smsc_mode_t        mode,
    output logic                        status_stale
);
    // link side
    logic [`SMSC_FRAME_BITS-1:0] rx_word;
    logic [`SMSC_CNT_W-1:0]      rx_count;
    logic                        frame_toggle;
    logic [`SMSC_FRAME_BITS-1:0] status_word_reg;

    smsc_spi_link u_link (
        .sclk         (sclk),
        .cs_n         (cs_n),
        .mosi         (mosi),
        .load_word    (status_word_reg),
        .miso         (miso),
        .rx_word      (rx_word),
        .rx_count     (rx_count),
        .frame_toggle (frame_toggle)
    );

    // synchronisers
    logic [2:0]            tog_sync_reg;
    logic [1:0]            cs_sync_reg;
    logic [1:0]            wake_sync_reg;
    logic [NUM_INPUTS-1:0] sw_meta_reg;
    logic [NUM_INPUTS-1:0] sw_sync_reg;
    logic [NUM_INPUTS-1:0] sw_prev_reg;
    logic                  cs_prev_reg;
    logic                  wake_prev_reg;

    // toggle sync is left out of reset: a toggle in flight at reset would
    // otherwise look like a fresh frame after release and replay it
    always_ff @(posedge clk) begin
        tog_sync_reg <= {tog_sync_reg[1:0], frame_toggle};
    end

    // wake line resets low: while awake our own output holds it there
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_sync_reg   <= 2'h3;
            wake_sync_reg <= 2'h0;
            wake_prev_reg <= 1'b0;
            sw_meta_reg   <= '0;
            sw_sync_reg   <= '0;
            sw_prev_reg   <= '0;
            cs_prev_reg   <= 1'b1;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], cs_n};
            wake_sync_reg <= {wake_sync_reg[0], wake_n_in};
            wake_prev_reg <= wake_sync_reg[1];
            sw_meta_reg   <= sw_below_thresh;
            sw_sync_reg   <= sw_meta_reg;
            sw_prev_reg   <= sw_sync_reg;
            cs_prev_reg   <= cs_sync_reg[1];
        end
    end

    logic frame_done;
    logic cs_fall;
    logic cs_low;
    logic sw_change;
    assign frame_done = tog_sync_reg[2] ^ tog_sync_reg[1];
    assign cs_low     = ~cs_sync_reg[1];
    assign cs_fall    = cs_prev_reg & ~cs_sync_reg[1];
    assign sw_change  = |(sw_sync_reg ^ sw_prev_reg);

    // rx_word and rx_count are static once the toggle is seen: cs_n is high
    // and sclk stands until the next frame, far longer than the sync delay
    logic       frame_ok;
    logic [7:0] opcode;
    assign frame_ok = frame_done && (rx_count == 5'(`SMSC_FRAME_BITS));
    assign opcode   = rx_word[`SMSC_OP_HI:`SMSC_OP_LO];

    // configuration registers
    logic [NUM_INPUTS-1:0] tristate_reg;
    logic [NUM_PROG-1:0]   to_batt_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            tristate_reg <= `SMSC_RST_TRISTATE;
        end else if (frame_ok && opcode == `SMSC_OP_TRISTATE_SP) begin
            tristate_reg[NUM_PROG-1:0] <= rx_word[NUM_PROG-1:0];
        end else if (frame_ok && opcode == `SMSC_OP_TRISTATE_SG) begin
            tristate_reg[NUM_INPUTS-1:NUM_PROG] <=
                rx_word[`SMSC_SG_DATA_HI:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            to_batt_reg <= `SMSC_RST_SETTINGS;
        end else if (frame_ok && opcode == `SMSC_OP_SETTINGS) begin
            to_batt_reg <= rx_word[NUM_PROG-1:0];
        end
    end

    // analog selection
    always_ff @(posedge clk) begin
        if (reset) begin
            analog_mux_out.sel   <= `SMSC_NO_ANALOG;
            analog_mux_out.cfg   <= smsc_pkg::SMSC_AN_HIZ;
            analog_mux_out.valid <= 1'b0;
        end else if (frame_ok && opcode == `SMSC_OP_ANALOG) begin
            analog_mux_out.sel <= rx_word[`SMSC_AN_SEL_HI:`SMSC_AN_SEL_LO];
            // reserved config code falls back to high impedance
            analog_mux_out.cfg <= (rx_word[`SMSC_AN_CFG_HI:`SMSC_AN_CFG_LO] == 2'h3)
                ? smsc_pkg::SMSC_AN_HIZ
                : smsc_pkg::smsc_an_cfg_t'(rx_word[`SMSC_AN_CFG_HI:`SMSC_AN_CFG_LO]);
            // out-of-range code disconnects the mux rather than aliasing
            analog_mux_out.valid <= (rx_word[`SMSC_AN_SEL_HI:`SMSC_AN_SEL_LO]
                                     < 5'(NUM_INPUTS));
        end
    end

    logic [NUM_INPUTS-1:0] analog_mask;
    always_comb begin
        analog_mask = '0;
        if (analog_mux_out.valid) begin
            analog_mask[analog_mux_out.sel] = 1'b1;
        end
    end

    // drive: programmable inputs sink when to-battery, source when to-ground
    logic [NUM_INPUTS-1:0] base_src;
    logic [NUM_PROG-1:0]   base_sink;
    always_comb begin
        base_src  = ~tristate_reg;
        base_sink = ~tristate_reg[NUM_PROG-1:0] & to_batt_reg;
        base_src[NUM_PROG-1:0] = ~tristate_reg[NUM_PROG-1:0] & ~to_batt_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            drive <= '0;
        end else if (mode == smsc_pkg::SMSC_SLEEP) begin
            drive <= '0;
        end else begin
            // analog input draws only the pull-up its analog config asks
            drive.source_en <= (base_src & ~analog_mask) |
                (analog_mux_out.cfg != smsc_pkg::SMSC_AN_HIZ ? analog_mask : '0);
            drive.sink_en   <= base_sink & ~analog_mask[NUM_PROG-1:0];
        end
    end

    // status word shifted out in the next frame
    always_ff @(posedge clk) begin
        if (reset) begin
            status_word_reg <= '0;
        end else begin
            // comparator reads even when tri-stated; analog input masked
            status_word_reg <= {{(`SMSC_FRAME_BITS-NUM_INPUTS){1'b0}},
                                sw_sync_reg & ~analog_mask};
        end
    end

    // sleep timer fields
    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_timers <= `SMSC_RST_TIMERS;
        end else if (frame_ok && opcode == `SMSC_OP_SLEEP) begin
            sleep_timers.int_code  <= rx_word[`SMSC_INT_TMR_HI:`SMSC_INT_TMR_LO];
            sleep_timers.scan_code <= rx_word[`SMSC_SCAN_TMR_HI:`SMSC_SCAN_TMR_LO];
        end
    end

    // a switch change seen while the sleep frame is being shifted vetoes sleep
    logic change_in_frame_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            change_in_frame_reg <= 1'b0;
        end else if (cs_low && sw_change) begin
            // set wins over the clear at cs_n fall
            change_in_frame_reg <= 1'b1;
        end else if (cs_fall) begin
            change_in_frame_reg <= 1'b0;
        end
    end

    // mode control
    // our own output holds the shared line low while awake, so only a fall
    // seen while asleep means another device is calling
    logic wake_req;
    assign wake_req = (wake_prev_reg & ~wake_sync_reg[1]) | cs_fall |
                      (frame_ok && opcode == `SMSC_OP_STATUS);

    always_ff @(posedge clk) begin
        if (reset) begin
            mode <= smsc_pkg::SMSC_NORMAL;
        end else begin
            case (mode)
                smsc_pkg::SMSC_NORMAL: begin
                    if (frame_ok && opcode == `SMSC_OP_SLEEP && !change_in_frame_reg
                        && !sw_change) begin
                        mode <= smsc_pkg::SMSC_SLEEP;
                    end
                end
                smsc_pkg::SMSC_SLEEP: begin
                    if (wake_req) begin
                        mode <= smsc_pkg::SMSC_NORMAL;
                    end
                end
                default: mode <= smsc_pkg::SMSC_NORMAL;
            endcase
        end
    end

    // wake pin: driven high while asleep, low while awake; output enable always on, line shared
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_n_out <= 1'b0;
            wake_n_oe  <= 1'b1;
        end else begin
            wake_n_out <= (mode == smsc_pkg::SMSC_SLEEP) && !wake_req;
            wake_n_oe  <= 1'b1;
        end
    end

    // first status after a wake may be invalid: inputs were unpowered
    always_ff @(posedge clk) begin
        if (reset) begin
            status_stale <= 1'b0;
        end else if (mode == smsc_pkg::SMSC_SLEEP) begin
            status_stale <= 1'b1;
        end else if (frame_ok && opcode == `SMSC_OP_STATUS) begin
            status_stale <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// *** rtl/smsc_map.svh ***
// constants and field layouts for the switch monitor sleep control block
// assumes inclusion by rtl/smsc_pkg.sv and rtl/smsc_core.sv; definitions only
`ifndef SMSC_MAP_SVH
`define SMSC_MAP_SVH

`define SMSC_FRAME_BITS      24
`define SMSC_CNT_W           5
`define SMSC_NUM_INPUTS      22
`define SMSC_NUM_PROG        8
`define SMSC_OP_HI           23
`define SMSC_OP_LO           16
`define SMSC_OP_STATUS       8'h00
`define SMSC_OP_SETTINGS     8'h01
`define SMSC_OP_TRISTATE_SP  8'h02
`define SMSC_OP_TRISTATE_SG  8'h03
`define SMSC_OP_ANALOG       8'h04
`define SMSC_OP_SLEEP        8'h0C
`define SMSC_AN_SEL_HI       4
`define SMSC_AN_SEL_LO       0
`define SMSC_AN_CFG_HI       6
`define SMSC_AN_CFG_LO       5
`define SMSC_INT_TMR_HI      5
`define SMSC_INT_TMR_LO      3
`define SMSC_SCAN_TMR_HI     2
`define SMSC_SCAN_TMR_LO     0
`define SMSC_SG_DATA_HI      13
`define SMSC_NO_ANALOG       5'h1F
`define SMSC_RST_TRISTATE    22'h3FFFFF
`define SMSC_RST_SETTINGS    8'hFF
`define SMSC_RST_TIMERS      6'h3F

`endif

// *** rtl/smsc_pkg.sv ***
// types shared by the switch monitor sleep control block
// assumes smsc_map.svh is on the include path
`include "smsc_map.svh"

package smsc_pkg;
    typedef enum logic [1:0] {
        SMSC_AN_HIZ,
        SMSC_AN_SMALL_PULLUP,
        SMSC_AN_LARGE_PULLUP,
        SMSC_AN_RSVD
    } smsc_an_cfg_t;

    typedef enum logic {
        SMSC_NORMAL,
        SMSC_SLEEP
    } smsc_mode_t;

    typedef struct packed {
        logic [`SMSC_NUM_INPUTS-1:0] source_en;
        logic [`SMSC_NUM_PROG-1:0]   sink_en;
    } smsc_drive_t;

    typedef struct packed {
        logic [4:0]   sel;
        smsc_an_cfg_t cfg;
        logic         valid;
    } smsc_analog_t;

    typedef struct packed {
        logic [2:0] int_code;
        logic [2:0] scan_code;
    } smsc_timers_t;
endpackage

// *** rtl/smsc_spi_link.sv ***
// spi shift engine on the link clock
// assumes sclk runs only while cs_n is low; frame framed by cs_n
`timescale 1ns/1ps
`default_nettype none
`include "smsc_map.svh"

module smsc_spi_link (
    input  wire logic                        sclk,
    input  wire logic                        cs_n,
    input  wire logic                        mosi,
    input  wire logic [`SMSC_FRAME_BITS-1:0] load_word,
    output logic                             miso,
    output logic [`SMSC_FRAME_BITS-1:0]      rx_word,
    output logic [`SMSC_CNT_W-1:0]           rx_count,
    output logic                             frame_toggle
);
    logic [`SMSC_FRAME_BITS-1:0] shift_reg;
    logic                        started_reg;
    logic [`SMSC_CNT_W-1:0]      bit_cnt_reg;
    // no reset reaches this domain; the toggle only has to start defined
    logic                        toggle_reg = 1'b0;

    // reset by cs_n high, so every frame starts clean without relying on sclk
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            started_reg <= 1'b0;
            shift_reg   <= '0;
            bit_cnt_reg <= '0;
        end else begin
            started_reg <= 1'b1;
            shift_reg   <= {(started_reg ? shift_reg[`SMSC_FRAME_BITS-2:0]
                                         : load_word[`SMSC_FRAME_BITS-2:0]), mosi};
            if (bit_cnt_reg != 5'h1F) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // msb out first; before the first edge the loaded word stands
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            miso <= 1'b0;
        end else begin
            miso <= started_reg ? shift_reg[`SMSC_FRAME_BITS-1]
                                : load_word[`SMSC_FRAME_BITS-1];
        end
    end

    // capture word and count at cs_n rise, before cs_n clears the counter;
    // both stand until the next rise, long after the toggle has crossed
    always_ff @(posedge cs_n) begin
        rx_word    <= shift_reg;
        rx_count   <= bit_cnt_reg;
        toggle_reg <= ~toggle_reg;
    end

    assign frame_toggle = toggle_reg;
endmodule

`default_nettype wire

// *** tb/smsc_host.sv ***
// host microcontroller side: spi master on an 80 ns link clock
// assumes the caller keeps at least 6 clk between frames
`timescale 1ns/1ps
`default_nettype none

module smsc_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // link clock stands still outside frames; odd offset keeps edges off clk
    task automatic xfer(input logic [31:0] w, input int n, inout logic [23:0] rx);
        #7 cs_n = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            mosi = w[31-i];
            #40 sclk = 1'b1;
            rx = {rx[22:0], miso};
            #40 sclk = 1'b0;
        end
        #40 cs_n = 1'b1;
        mosi = ~mosi;
    endtask
endmodule

`default_nettype wire

// *** tb/smsc_props.sv ***
// concurrent checks on the switch monitor core ports
// assumes bound into smsc_core; one clk domain with synchronous reset
`timescale 1ns/1ps
`default_nettype none

module smsc_props #(
    parameter int NUM_INPUTS = 22,
    parameter int NUM_PROG   = 8
) (
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   cs_n,
    input wire logic                   wake_n_in,
    input wire logic                   wake_n_out,
    input wire logic                   wake_n_oe,
    input wire smsc_pkg::smsc_drive_t  drive,
    input wire smsc_pkg::smsc_analog_t analog_mux_out,
    input wire smsc_pkg::smsc_timers_t sleep_timers,
    input wire smsc_pkg::smsc_mode_t   mode,
    input wire logic                   status_stale
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_asleep;
        mode == smsc_pkg::SMSC_SLEEP ##1 mode == smsc_pkg::SMSC_SLEEP;
    endsequence
    sequence s_awake;
        mode == smsc_pkg::SMSC_NORMAL ##1 mode == smsc_pkg::SMSC_NORMAL;
    endsequence

    rst_defaults_a: assert property (
        disable iff (1'b0) reset |=> mode == smsc_pkg::SMSC_NORMAL && drive == 30'h0
        && sleep_timers == 6'h3F && !analog_mux_out.valid && wake_n_oe)
        else $error("defaults missing after reset");
    asleep_wake_a: assert property (s_asleep |-> wake_n_out)
        else $error("wake output low while asleep");
    awake_wake_a: assert property (s_awake |-> !wake_n_out)
        else $error("wake output high while awake");
    sleep_drive_a: assert property (s_asleep |-> drive == 30'h0 && status_stale)
        else $error("sources on or status fresh in sleep");
    config_hold_a: assert property (
        (!cs_n) [*6] |=> $stable(sleep_timers) && $stable(analog_mux_out))
        else $error("settings changed inside a frame");
    line_wake_a: assert property (
        mode == smsc_pkg::SMSC_SLEEP && $fell(wake_n_in) |-> ##[1:8] mode == smsc_pkg::SMSC_NORMAL)
        else $error("shared wake line ignored");
    cs_wake_a: assert property (
        mode == smsc_pkg::SMSC_SLEEP && $fell(cs_n) |-> ##[1:8] mode == smsc_pkg::SMSC_NORMAL)
        else $error("select fall did not wake");
    analog_ok_a: assert property (analog_mux_out.valid |->
        analog_mux_out.sel < NUM_INPUTS && analog_mux_out.cfg != smsc_pkg::SMSC_AN_RSVD)
        else $error("bad analog selection");
    drive_excl_a: assert property ((drive.sink_en & drive.source_en[NUM_PROG-1:0]) == 8'h00)
        else $error("input both sinks and sources");
endmodule

bind smsc_core smsc_props #(.NUM_INPUTS(NUM_INPUTS), .NUM_PROG(NUM_PROG)) i_smsc_props (
    .clk, .reset, .cs_n, .wake_n_in, .wake_n_out, .wake_n_oe, .drive, .analog_mux_out,
    .sleep_timers, .mode, .status_stale);

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the switch monitor core against a behavioural model
// assumes the host model in smsc_host.sv and the map header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "smsc_map.svh"
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD %0t %s", $time, m); end end

module tb;
    logic                   clk;
    logic                   reset;
    logic [21:0]            sw;
    logic                   peer_n;
    logic                   sclk, cs_n, mosi, miso, wake_n_out, wake_n_oe, stale;
    smsc_pkg::smsc_drive_t  drive;
    smsc_pkg::smsc_analog_t an;
    smsc_pkg::smsc_timers_t tmr;
    smsc_pkg::smsc_mode_t   mode;
    int                     n_mismatch, num_checks;
    logic [21:0]            m_tri, m_st;
    logic [7:0]             m_bat;
    logic [6:0]             m_an;
    logic                   m_av, m_slp;
    logic [5:0]             m_tmr;
    logic [23:0]            rx;
    logic [7:0]             ops[$];
    wire logic              wake_line = (wake_n_oe ? wake_n_out : 1'b1) & peer_n;

    smsc_core i_smsc_core (.clk, .reset, .sclk, .cs_n, .mosi, .miso, .sw_below_thresh(sw),
        .wake_n_in(wake_line), .wake_n_out, .wake_n_oe, .drive, .analog_mux_out(an),
        .sleep_timers(tmr), .mode, .status_stale(stale));
    smsc_host i_smsc_host (.sclk, .cs_n, .mosi, .miso);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check_all(input logic chk_rx);
        smsc_pkg::smsc_drive_t e;
        logic [29:0]           mk;
        e.source_en = ~m_tri;
        e.source_en[7:0] = ~m_tri[7:0] & ~m_bat;
        e.sink_en = ~m_tri[7:0] & m_bat;
        if (m_slp) e = 30'h0;
        // an analog input's own source is set by its analog configuration
        mk = m_av ? (30'h1 << (m_an[4:0] + 8)) | (m_an[4:0] < 8 ? 30'h1 << m_an[4:0] : 30'h0) : 0;
        `CHK(drive | mk, e | mk, "drive")
        `CHK(mode, m_slp ? smsc_pkg::SMSC_SLEEP : smsc_pkg::SMSC_NORMAL, "mode")
        `CHK({an.valid, an.valid ? {an.cfg, an.sel} : 7'h0}, {m_av, m_av ? m_an : 7'h0}, "mux")
        `CHK(tmr, m_tmr, "timers")
        `CHK(wake_n_out, m_slp, "wake level")
        `CHK(wake_n_oe, 1'b1, "wake enable")
        if (m_av && !m_slp) `CHK(drive.source_en[m_an[4:0]], m_an[6:5] != 2'h0, "pull")
        if (chk_rx) `CHK(rx, {2'b00, m_st}, "status")
    endtask

    task automatic frame(input logic [23:0] w, input int n = 24);
        i_smsc_host.xfer({w, 8'h00}, n, rx);
        repeat (8) @(posedge clk);
    endtask

    task automatic send(input logic [23:0] w);
        logic was_slp;
        was_slp = m_slp;
        m_st = sw & ~(m_av ? 22'h1 << m_an[4:0] : 22'h0);
        frame(w);
        case (w[23:16])
            `SMSC_OP_SETTINGS: m_bat = w[7:0];
            `SMSC_OP_TRISTATE_SP: m_tri[7:0] = w[7:0];
            `SMSC_OP_TRISTATE_SG: m_tri[21:8] = w[13:0];
            `SMSC_OP_ANALOG: m_an = {w[6:5] == 2'h3 ? 2'h0 : w[6:5], w[4:0]};
            `SMSC_OP_SLEEP: {m_tmr, m_slp} = {w[5:0], 1'b1};
            default: m_slp = 1'b0;
        endcase
        if (w[23:16] == `SMSC_OP_ANALOG) m_av = w[4:0] < 5'h16;
        // the frame that wakes the device may carry stale status
        check_all(w[23:16] == `SMSC_OP_STATUS && !was_slp);
        if (w[23:16] == `SMSC_OP_SLEEP || w[23:16] == `SMSC_OP_STATUS)
            `CHK(stale, w[23:16] == `SMSC_OP_SLEEP, "stale flag")
    endtask

    task automatic rst();
        @(posedge clk);
        reset <= 1'b1;
        {m_tri, m_bat, m_an, m_av, m_tmr, m_slp} = {22'h3FFFFF, 8'hFF, 7'h1F, 1'b0, 6'h3F, 1'b0};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge clk);
        check_all(1'b0);
        $display("reset defaults done");
    endtask

    task automatic wait_awake();
        int k;
        for (k = 0; k < 20 && mode !== smsc_pkg::SMSC_NORMAL; k++) @(posedge clk);
        m_slp = 1'b0;
        `CHK(mode, smsc_pkg::SMSC_NORMAL, "no wake")
        if (k == 20) conclude();
    endtask

    initial begin
        {reset, peer_n, sw, n_mismatch, num_checks} = {1'b1, 1'b1, 22'h0, 32'd0, 32'd0};
        ops = '{`SMSC_OP_STATUS, `SMSC_OP_SETTINGS, `SMSC_OP_TRISTATE_SP,
                `SMSC_OP_TRISTATE_SG, `SMSC_OP_ANALOG};
        void'($urandom(76));
        rst();
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            sw <= 22'($urandom);
            repeat (4) @(posedge clk);
            send({ops[$urandom % 5], 16'($urandom)});
        end
        $display("random commands done");
        frame({`SMSC_OP_SLEEP, 16'h0000}, 23);
        frame({`SMSC_OP_SLEEP, 16'h0000}, 25);
        check_all(1'b0);
        send({`SMSC_OP_SLEEP, 16'h0015});
        `CHK(wake_n_out, 1'b1, "wake level asleep")
        frame(24'h000000, 0);
        wait_awake();
        check_all(1'b0);
        send({`SMSC_OP_SLEEP, 16'h0038});
        @(posedge clk);
        peer_n <= 1'b0;
        wait_awake();
        @(posedge clk);
        peer_n <= 1'b1;
        send({`SMSC_OP_SLEEP, 16'h0007});
        send({`SMSC_OP_STATUS, 16'h0000});
        // settle wait shortened: modelled inputs settle at once
        send({`SMSC_OP_STATUS, 16'h0000});
        $display("sleep and wake done");
        fork
            frame({`SMSC_OP_SLEEP, 16'h0007});
            begin
                repeat (20) @(posedge clk);
                sw <= ~sw;
            end
        join
        check_all(1'b0);
        $display("sleep veto done");
        rst();
        send({`SMSC_OP_TRISTATE_SG, 16'h0000});
        conclude();
    end
endmodule

`default_nettype wire
